// File: rtl/awk_defines.svh
// constants of the stop-mode auto wakeup timer: register offsets,
// field positions, reset values and wakeup periods
// assumes a 32-bit classic wishbone slave, byte addresses, one word each
`ifndef AWK_DEFINES_SVH
`define AWK_DEFINES_SVH

// register byte offsets
`define AWK_OFS_PORT_A      8'h00
`define AWK_OFS_KEYPAD_SC   8'h04
`define AWK_OFS_KEYPAD_IE   8'h08
`define AWK_OFS_OPTION_ONE  8'h0c
`define AWK_OFS_OPTION_TWO  8'h10
// field positions
`define AWK_BIT_WAKE_LATCH  6
`define AWK_BIT_PENDING     3
`define AWK_BIT_ACK         2
`define AWK_BIT_MASK        1
`define AWK_BIT_WAKE_IE     6
`define AWK_BIT_PERIOD_SEL  0
`define AWK_BIT_KEEP_CLK    1
// reset values of the writable bits
`define AWK_RST_MASK        1'b0
`define AWK_RST_WAKE_IE     1'b0
`define AWK_RST_PERIOD_SEL  1'b0
`define AWK_RST_KEEP_CLK    1'b0
// wakeup periods in wakeup clock periods
`define AWK_SHORT_PERIOD    512
`define AWK_LONG_PERIOD     16384
`define AWK_CNT_W           14
`endif

// File: rtl/awk_pkg.sv
// types of the stop-mode auto wakeup timer
// assumes awk_defines.svh for all numbers
package awk_pkg;
   // generator state: counting in stop without wait, idle otherwise
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_COUNT
   } awk_state_t;

   // software-written control bits travelling together
   typedef struct packed {
      logic mask;         // keypad irq mask
      logic wake_ie;      // wake irq enable
      logic period_sel;   // 1 short, 0 long
      logic keep_clk;     // 1 doubled bus clock, 0 rc oscillator
   } awk_ctrl_t;
endpackage

// File: rtl/awk_auto_wake.sv
// stop-mode auto wakeup timer with its share of the keypad interrupt
// logic and a classic wishbone register slave
// assumes stop and wait flags come from logic on clk_i, and that both
// wakeup clocks are slow pins sampled here against clk_i
// limitation: each wakeup clock must stay slower than a quarter of clk_i,
// since both are sampled; their edges are ignored outside stop
//
// What this block does
// RQ1 - periodic wakeups leave stop without pin events
// RQ2 - entering stop alone starts request generation
// RQ3 - wake_irq_enable bit gates the wakeup input
// RQ4 - request while enabled sets the wake latch
// RQ5 - latch readable read-only at port a bit 6
// RQ6 - no other port bits at position 6
// RQ7 - keep-clock bit picks doubled bus clock, else rc
// RQ8 - counter overflow latches request for keypad logic
// RQ9 - interrupt only when enabled, keypad vector
// RQ10 - period select one short, zero long
// RQ11 - acknowledge write or reset clears latch
// RQ12 - enable bit does not alter latch readback
// RQ13 - counters idle in run, active in stop
// RQ14 - nothing active and no requests in wait
// RQ15 - enabled module starts itself on stop entry
// RQ16 - software clears mask to allow stop exit
// RQ17 - counters restart from zero each stop entry
// RQ18 - short 512, long 16384 wakeup clock periods
// RQ19 - acknowledge bit write-only, reads zero, resets zero
// RQ20 - pending flag read-only, set while request pending
// RQ21 - mask set blocks interrupts, reset clears mask
// RQ22 - counter wide enough, overflow synchronised to clk_i
`timescale 1ns/100ps
`include "awk_defines.svh"

module awk_auto_wake #(
   parameter int unsigned LONG_PERIOD = `AWK_LONG_PERIOD  // shorten in simulation
) (
   input  wire logic        clk_i,           // 200 mhz system clock
   input  wire logic        rst_i,           // synchronous, active high
   input  wire logic        stop_mode_i,     // cpu is in stop mode
   input  wire logic        wait_mode_i,     // cpu is in wait mode
   input  wire logic        rc_osc_i,        // dedicated rc oscillator pin
   input  wire logic        bus_clk_x2_i,    // doubled bus clock pin
   input  wire logic        wb_cyc_i,        // wishbone cycle
   input  wire logic        wb_stb_i,        // wishbone strobe
   input  wire logic        wb_we_i,         // wishbone write
   input  wire logic [7:0]  wb_adr_i,        // byte address
   input  wire logic [3:0]  wb_sel_i,        // byte lanes
   input  wire logic [31:0] wb_dat_i,        // write data
   output logic      [31:0] wb_dat_o,        // read data, registered
   output logic             wb_ack_o,        // one-cycle acknowledge
   output logic             keypad_irq_o,    // keypad vector request
   output logic             wake_request_o   // stop exit request
);

   // ---------------- wakeup clock synchronisers ----------------
   logic       rc_meta_q;        // first stage, read only by second
   logic       rc_sync_q;        // rc level in clk_i domain
   logic       rc_prev_q;        // for edge detection
   logic       bx_meta_q;        // first stage, read only by second
   logic       bx_sync_q;        // doubled bus clock in clk_i domain
   logic       bx_prev_q;        // for edge detection

   // ---------------- generator ----------------
   awk_pkg::awk_state_t          state_q;     // idle or counting
   awk_pkg::awk_state_t          state_d;
   logic [`AWK_CNT_W-1:0]        cnt_q;       // wakeup clock edge count
   logic [`AWK_CNT_W-1:0]        cnt_d;
   logic                         wake_request_pulse;  // one-cycle overflow

   // ---------------- software state ----------------
   awk_pkg::awk_ctrl_t ctrl_q;                // control bits
   awk_pkg::awk_ctrl_t ctrl_d;
   logic               wake_request_latch_q;  // sticky wakeup request
   logic               wake_request_latch_d;
   logic               ack_q;                 // bus acknowledge
   logic [31:0]        rdat_q;                // read data
   logic               irq_q;                 // interrupt output
   logic               stop_out_q;            // stop exit output

   // ---------------- synchroniser flops ----------------
   // every pin passes two flops; only the second stage is looked at
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_meta_q <= 1'b0;
         rc_sync_q <= 1'b0;
         rc_prev_q <= 1'b0;
         bx_meta_q <= 1'b0;
         bx_sync_q <= 1'b0;
         bx_prev_q <= 1'b0;
      end else begin
         rc_meta_q <= rc_osc_i;
         rc_sync_q <= rc_meta_q;
         rc_prev_q <= rc_sync_q;
         bx_meta_q <= bus_clk_x2_i;
         bx_sync_q <= bx_meta_q;
         bx_prev_q <= bx_sync_q;
      end
   end

   // rising edges of each source, already in the clk_i domain
   wire rc_rise  = rc_sync_q & ~rc_prev_q;
   wire bx_rise  = bx_sync_q & ~bx_prev_q;
   // source choice; the bus clock is only useful when kept alive in stop
   wire src_rise = ctrl_q.keep_clk ? bx_rise : rc_rise;  // RQ7

   // ---------------- generator decode ----------------
   // wait mode overrides: no counting even if stop is also claimed
   wire active   = stop_mode_i & ~wait_mode_i;  // RQ2 RQ13 RQ14 RQ15
   wire [`AWK_CNT_W-1:0] period_last =
      ctrl_q.period_sel ? `AWK_CNT_W'(`AWK_SHORT_PERIOD - 1)
                        : `AWK_CNT_W'(LONG_PERIOD - 1);  // RQ10 RQ18 RQ22
   wire at_last  = (cnt_q == period_last);
   // overflow is born in clk_i, so it needs no further crossing;
   // gating by active drops a last edge that meets wait or the end of stop
   assign wake_request_pulse = (state_q == awk_pkg::ST_COUNT) & active & src_rise
                               & at_last;  // RQ1 RQ8 RQ14 RQ22

   // next state and count
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         awk_pkg::ST_IDLE: begin
            cnt_d = '0;  // RQ17
            if (active) begin
               state_d = awk_pkg::ST_COUNT;  // RQ2
            end
         end
         awk_pkg::ST_COUNT: begin
            if (!active) begin
               // leaving stop drops the count so the next entry starts clean
               state_d = awk_pkg::ST_IDLE;  // RQ13
               cnt_d   = '0;  // RQ17
            end else if (src_rise) begin
               // wrap at overflow for a periodic request
               cnt_d = at_last ? '0 : cnt_q + `AWK_CNT_W'(1);  // RQ8
            end
         end
         default: begin
            state_d = awk_pkg::ST_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   // generator flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= awk_pkg::ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ---------------- wishbone decode ----------------
   wire bus_req   = wb_cyc_i & wb_stb_i;
   // write commits on the edge that shows ack, the edge the master samples
   wire wr_commit = bus_req & wb_we_i & ack_q & wb_sel_i[0];
   wire hit_pa    = (wb_adr_i == `AWK_OFS_PORT_A);
   wire hit_sc    = (wb_adr_i == `AWK_OFS_KEYPAD_SC);
   wire hit_ie    = (wb_adr_i == `AWK_OFS_KEYPAD_IE);
   wire hit_o1    = (wb_adr_i == `AWK_OFS_OPTION_ONE);
   wire hit_o2    = (wb_adr_i == `AWK_OFS_OPTION_TWO);
   // port a bit 6 takes no writes; its latch is cleared only by a write of the acknowledge bit or by reset
   wire ack_write = wr_commit & hit_sc & wb_dat_i[`AWK_BIT_ACK];  // RQ11 RQ19

   // ---------------- control and latch next values ----------------
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_commit & hit_sc) begin
         ctrl_d.mask = wb_dat_i[`AWK_BIT_MASK];  // RQ21 RQ16
      end
      if (wr_commit & hit_ie) begin
         ctrl_d.wake_ie = wb_dat_i[`AWK_BIT_WAKE_IE];  // RQ3
      end
      if (wr_commit & hit_o1) begin
         ctrl_d.period_sel = wb_dat_i[`AWK_BIT_PERIOD_SEL];  // RQ10
      end
      if (wr_commit & hit_o2) begin
         ctrl_d.keep_clk = wb_dat_i[`AWK_BIT_KEEP_CLK];  // RQ7
      end
   end

   // set beats acknowledge so a request in the clearing cycle survives
   assign wake_request_latch_d =
      (wake_request_pulse & ctrl_q.wake_ie)  // RQ4 RQ9
      | (wake_request_latch_q & ~ack_write);  // RQ11

   // pending flag mirrors the latch; no keypad pins feed this block
   wire pending = wake_request_latch_q;  // RQ20
   wire irq_d   = pending & ~ctrl_q.mask;  // RQ9 RQ21 RQ16

   // read mux; unmapped offsets and unused bits read zero
   wire [31:0] rd_pa = 32'(wake_request_latch_q) << `AWK_BIT_WAKE_LATCH;  // RQ5 RQ6 RQ12
   wire [31:0] rd_sc = (32'(pending) << `AWK_BIT_PENDING)
                     | (32'(ctrl_q.mask) << `AWK_BIT_MASK);  // RQ19 RQ20
   wire [31:0] rd_ie = 32'(ctrl_q.wake_ie) << `AWK_BIT_WAKE_IE;
   wire [31:0] rd_o1 = 32'(ctrl_q.period_sel) << `AWK_BIT_PERIOD_SEL;
   wire [31:0] rd_o2 = 32'(ctrl_q.keep_clk) << `AWK_BIT_KEEP_CLK;
   wire [31:0] rd_mux = hit_pa ? rd_pa :
                        hit_sc ? rd_sc :
                        hit_ie ? rd_ie :
                        hit_o1 ? rd_o1 :
                        hit_o2 ? rd_o2 : 32'h0000_0000;

   // register flops; reset leaves everything cleared, mask included, and idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q.mask          <= `AWK_RST_MASK;  // RQ21
         ctrl_q.wake_ie       <= `AWK_RST_WAKE_IE;
         ctrl_q.period_sel    <= `AWK_RST_PERIOD_SEL;
         ctrl_q.keep_clk      <= `AWK_RST_KEEP_CLK;
         wake_request_latch_q <= 1'b0;  // RQ11
      end else begin
         ctrl_q               <= ctrl_d;
         wake_request_latch_q <= wake_request_latch_d;
      end
   end

   // bus answer: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req & ~ack_q;
         rdat_q <= (bus_req & ~ack_q & ~wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // interrupt outputs, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q      <= 1'b0;
         stop_out_q <= 1'b0;
      end else begin
         irq_q      <= irq_d;  // RQ9
         stop_out_q <= irq_d;  // RQ1 RQ16
      end
   end

   assign wb_ack_o       = ack_q;
   assign wb_dat_o       = rdat_q;
   assign keypad_irq_o   = irq_q;
   assign wake_request_o = stop_out_q;

   // ---------------- assertions ----------------
   sequence s_enabled_overflow;
      wake_request_pulse && ctrl_q.wake_ie;
   endsequence
   sequence s_unmasked_pending;
      wake_request_latch_q && !ctrl_q.mask;
   endsequence
   sequence s_counting;
      (state_q == awk_pkg::ST_COUNT) && active;
   endsequence
   sequence s_read_taken;
      bus_req && !ack_q && !wb_we_i;
   endsequence

   latch_set_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ4
      s_enabled_overflow |=> wake_request_latch_q)
      else $error("enabled overflow did not set latch");
   latch_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ11
      (ack_write && !wake_request_pulse) |=> !wake_request_latch_q)
      else $error("acknowledge did not clear latch");
   latch_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ3
      (!wake_request_latch_q && !ctrl_q.wake_ie) |=> !wake_request_latch_q)
      else $error("latch set while wake irq disabled");
   irq_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ21
      (ctrl_q.mask && $stable(ctrl_q.mask)) |=> !keypad_irq_o)
      else $error("masked request raised interrupt");
   irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ9
      s_unmasked_pending |=> (keypad_irq_o && wake_request_o))
      else $error("pending unmasked request gave no interrupt");
   cnt_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ17
      (!active) |=> (cnt_q == '0))
      else $error("counter not zero outside stop");
   wait_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ14
      wait_mode_i |-> !wake_request_pulse)
      else $error("wakeup request during wait");
   period_end_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ18
      wake_request_pulse |-> (cnt_q == (ctrl_q.period_sel
         ? `AWK_CNT_W'(`AWK_SHORT_PERIOD - 1) : `AWK_CNT_W'(LONG_PERIOD - 1)))
      ##1 (cnt_q == '0))
      else $error("overflow not at selected period");
   port_read_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ5
      (bus_req && !ack_q && !wb_we_i && hit_pa) |=>
      (wb_ack_o && wb_dat_o == (32'($past(wake_request_latch_q)) << 6)))
      else $error("port a read does not show latch");
   ack_reads_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ19
      wb_ack_o |-> !wb_dat_o[`AWK_BIT_ACK] ##1 !wb_ack_o)
      else $error("acknowledge bit read nonzero or ack too long");

   // every taken request is answered in the next cycle
   bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_req && !ack_q) |=> wb_ack_o)
      else $error("taken request got no acknowledge");
   // run mode lets no overflow escape
   idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ13
      !stop_mode_i |-> !wake_request_pulse)
      else $error("wakeup request outside stop");
   // rc source chosen: the count moves only on rc edges
   rc_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ7
      (active && !ctrl_q.keep_clk && !rc_rise) |=> $stable(cnt_q))
      else $error("counter moved without rc edge");
   // bus clock chosen: the count moves only on its edges
   bx_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ7
      (active && ctrl_q.keep_clk && !bx_rise) |=> $stable(cnt_q))
      else $error("counter moved without bus clock edge");
   // first cycle of stop starts a clean count
   stop_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ2 RQ17
      (state_q == awk_pkg::ST_IDLE && active) |=>
      (state_q == awk_pkg::ST_COUNT && cnt_q == '0))
      else $error("stop entry did not start a clean count");
   // each counted edge before the last steps the count by one
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ8
      s_counting ##0 (src_rise && !at_last) |=> (cnt_q == $past(cnt_q) + 1'b1))
      else $error("counter did not step on wakeup edge");
   // the latch is sticky until acknowledged
   latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ11
      (wake_request_latch_q && !ack_write) |=> wake_request_latch_q)
      else $error("latch dropped without acknowledge");
   // port a writes never touch the latch
   port_write_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ5
      (wr_commit && hit_pa && !wake_request_pulse) |=> $stable(wake_request_latch_q))
      else $error("port a write changed latch");
   // pending flag read back equals the latch
   flag_read_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ20
      s_read_taken ##0 hit_sc |=>
      (wb_dat_o[`AWK_BIT_PENDING] == $past(wake_request_latch_q)))
      else $error("pending flag read does not show latch");
   // control writes land on the ack edge
   ie_write_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ3
      (wr_commit && hit_ie) |=> (ctrl_q.wake_ie == $past(wb_dat_i[`AWK_BIT_WAKE_IE])))
      else $error("wake irq enable write lost");
   // period select write reaches the counter compare
   period_write_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ10
      (wr_commit && hit_o1) |=>
      (ctrl_q.period_sel == $past(wb_dat_i[`AWK_BIT_PERIOD_SEL])))
      else $error("period select write lost");
   // keep-clock write reaches the source choice
   keep_write_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ7
      (wr_commit && hit_o2) |=>
      (ctrl_q.keep_clk == $past(wb_dat_i[`AWK_BIT_KEEP_CLK])))
      else $error("keep clock write lost");

endmodule // awk_auto_wake

// File: sim/awk_cpu_model.sv
// cpu side model: stop and wait levels plus both wakeup clock pins
// assumes requests come from the bench by nba on clk_i rising edges
`timescale 1ns/100ps

module awk_cpu_model (
   input  wire logic clk_i,        // system clock
   input  wire logic rst_i,        // sync reset, active high
   input  wire logic stop_req_i,   // software asks for stop
   input  wire logic wait_req_i,   // software asks for wait
   input  wire logic wake_i,       // stop exit request
   output logic      stop_mode_o,  // cpu in stop
   output logic      wait_mode_o,  // cpu in wait
   output logic      rc_osc_o,     // rc pin, period 8 clocks
   output logic      bus_clk_x2_o  // doubled bus clock, period 6 clocks
);
   logic       woke_q; // woken, held until the stop request drops
   logic [3:0] div_q;  // mod-12 divider shared by both pins

   // a wakeup ends stop until software asks again
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_mode_o <= 1'b0;
         wait_mode_o <= 1'b0;
         woke_q      <= 1'b0;
      end else begin
         stop_mode_o <= stop_req_i & ~wake_i & ~woke_q;
         wait_mode_o <= wait_req_i;
         woke_q      <= wake_i | (woke_q & stop_req_i);
      end
   end

   // pins run free; the block must ignore them outside stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q        <= 4'h0;
         rc_osc_o     <= 1'b0;
         bus_clk_x2_o <= 1'b0;
      end else begin
         div_q <= (div_q == 4'hb) ? 4'h0 : div_q + 4'h1;
         if (div_q[1:0] == 2'h3) begin
            rc_osc_o <= ~rc_osc_o;
         end
         if (div_q % 3 == 2) begin
            bus_clk_x2_o <= ~bus_clk_x2_o;
         end
      end
   end
endmodule // awk_cpu_model

// File: sim/tb_top.sv
// bench for the auto wakeup timer: wishbone tasks and scenarios
// assumes the cpu model drives stop, wait and both clock pins
`timescale 1ns/100ps
`include "awk_defines.svh"

module tb_top;
   logic        clk_i = 1'b0; // 200 mhz
   logic        rst_i;        // sync reset
   logic        stop_req;     // to cpu model
   logic        wait_req;     // to cpu model
   logic        stop_m;       // cpu model outputs
   logic        wait_m;
   logic        rc_osc;
   logic        bus_x2;
   logic        cyc;          // wishbone master side
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic [31:0] q;            // last read word
   logic        ack;
   logic        irq;
   logic        wake;
   int          miscompares = 0;
   int          tests_run = 0;
   localparam logic [7:0] PA = `AWK_OFS_PORT_A;
   localparam logic [7:0] SC = `AWK_OFS_KEYPAD_SC;
   localparam logic [7:0] IE = `AWK_OFS_KEYPAD_IE;

   always #2.5 clk_i = ~clk_i;

   // long period shortened to 32 wakeup clocks
   awk_auto_wake #(.LONG_PERIOD(32)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .stop_mode_i(stop_m),
      .wait_mode_i(wait_m), .rc_osc_i(rc_osc), .bus_clk_x2_i(bus_x2),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .keypad_irq_o(irq), .wake_request_o(wake));

   awk_cpu_model u_cpu (
      .clk_i(clk_i), .rst_i(rst_i), .stop_req_i(stop_req),
      .wait_req_i(wait_req), .wake_i(wake), .stop_mode_o(stop_m),
      .wait_mode_o(wait_m), .rc_osc_o(rc_osc), .bus_clk_x2_o(bus_x2));

   task automatic final_report;
      $display("compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one classic cycle; held until ack is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         $display("MISMATCH %0t: no bus acknowledge", $time);
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   task automatic stop_set(input logic v);
      @(posedge clk_i);
      stop_req <= v;
   endtask

   // cycles from stop request to wake, bounded by the window
   task automatic wake_time(input int lo, input int hi);
      int n;
      n = 0;
      while (wake !== 1'b1 && n < hi + 20) begin
         @(posedge clk_i);
         n++;
      end
      tests_run++;
      if (n < lo || n > hi) begin
         miscompares++;
         $display("MISMATCH %0t: wake after %0d cycles", $time, n);
         if (wake !== 1'b1) final_report();
      end
   endtask

   initial begin
      rst_i = 1'b1;
      {stop_req, wait_req, cyc, stb, we} = 5'h00;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, unmapped 0x20 included
      rd(PA, 32'h0);
      rd(SC, 32'h0);
      rd(IE, 32'h0);
      rd(`AWK_OFS_OPTION_ONE, 32'h0);
      rd(`AWK_OFS_OPTION_TWO, 32'h0);
      rd(8'h20, 32'h0);
      wr(PA, 32'hff);
      rd(PA, 32'h0);
      wr(SC, 32'h06);
      rd(SC, 32'h02);
      wr(SC, 32'h0);
      $display("test regs done");
      // run mode and wait mode must not count
      wr(IE, 32'h40);
      repeat (400) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0);
      wait_req <= 1'b1;
      stop_set(1'b1);
      repeat (400) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0);
      rd(PA, 32'h0);
      stop_set(1'b0);
      wait_req <= 1'b0;
      $display("test idle done");
      // long period on the rc pin
      stop_set(1'b1);
      wake_time(245, 275);
      rd(PA, 32'h40);
      rd(SC, 32'h08);
      chk({31'h0, irq}, 32'h1);
      stop_set(1'b0);
      wr(SC, 32'h04);
      rd(SC, 32'h0);
      rd(PA, 32'h0);
      // counter restarts on a second entry
      stop_set(1'b1);
      repeat (200) @(posedge clk_i);
      stop_set(1'b0);
      repeat (10) @(posedge clk_i);
      stop_set(1'b1);
      wake_time(245, 275);
      stop_set(1'b0);
      wr(SC, 32'h04);
      $display("test long done");
      // short period on the doubled bus clock
      wr(`AWK_OFS_OPTION_ONE, 32'h01);
      wr(`AWK_OFS_OPTION_TWO, 32'h02);
      rd(`AWK_OFS_OPTION_ONE, 32'h01);
      rd(`AWK_OFS_OPTION_TWO, 32'h02);
      stop_set(1'b1);
      wake_time(3060, 3090);
      stop_set(1'b0);
      wr(SC, 32'h04);
      wr(`AWK_OFS_OPTION_ONE, 32'h0);
      wr(`AWK_OFS_OPTION_TWO, 32'h0);
      $display("test short done");
      // enable off: overflow ignored
      wr(IE, 32'h0);
      stop_set(1'b1);
      repeat (400) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0);
      rd(PA, 32'h0);
      stop_set(1'b0);
      // mask holds the request back until cleared
      wr(IE, 32'h40);
      wr(SC, 32'h02);
      stop_set(1'b1);
      repeat (300) @(posedge clk_i);
      chk({31'h0, wake}, 32'h0);
      rd(PA, 32'h40);
      rd(SC, 32'h0a);
      wr(IE, 32'h0);
      rd(PA, 32'h40);
      wr(SC, 32'h0);
      repeat (3) @(posedge clk_i);
      chk({31'h0, wake}, 32'h1);
      stop_set(1'b0);
      wr(SC, 32'h04);
      rd(PA, 32'h0);
      $display("test mask done");
      // a reset in mid-run clears a set latch
      wr(IE, 32'h40);
      stop_set(1'b1);
      wake_time(245, 275);
      @(posedge clk_i);
      rst_i <= 1'b1;
      stop_req <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(PA, 32'h0);
      rd(IE, 32'h0);
      chk({31'h0, wake}, 32'h0);
      $display("test reset done");
      final_report();
   end
endmodule // tb_top
